// ==== rtl/nsh_pkg.sv ====
// package for the nand-style host port controller
// assumes a single 200 MHz system clock; shared by host and fifo
package nsh_pkg;

  // ****************************************************
  // command bytes
  // ****************************************************
  localparam logic [7:0] NSH_CMD_READ_ID    = 8'h90;
  localparam logic [7:0] NSH_CMD_READ_PARAM = 8'hEC;
  localparam logic [7:0] NSH_CMD_STATUS     = 8'h70;
  localparam logic [7:0] NSH_CMD_READ       = 8'h00;
  localparam logic [7:0] NSH_CMD_READ_CONF  = 8'h30;
  localparam logic [7:0] NSH_CMD_WRITE      = 8'h80;
  localparam logic [7:0] NSH_CMD_WRITE_CONF = 8'h10;
  localparam logic [7:0] NSH_CMD_RESET      = 8'hFF;
  localparam logic [7:0] NSH_CMD_RECALL     = 8'hFC;
  localparam logic [7:0] NSH_CMD_STORE      = 8'h84;
  localparam logic [7:0] NSH_CMD_STORE_CONF = 8'hA5;
  localparam logic [7:0] NSH_CMD_AS_DIS     = 8'hA3;
  localparam logic [7:0] NSH_CMD_AS_EN      = 8'hAC;

  // ****************************************************
  // host operation codes (user side)
  // ****************************************************
  localparam logic [2:0] NSH_OP_COMMAND = 3'h0; // single command byte
  localparam logic [2:0] NSH_OP_READ    = 3'h1; // cmd, 5 addr, confirm, reads
  localparam logic [2:0] NSH_OP_WRITE   = 3'h2; // cmd, 5 addr, writes, optional confirm
  localparam logic [2:0] NSH_OP_ADDR    = 3'h3; // cmd + one address byte + reads
  localparam logic [2:0] NSH_OP_STATUS  = 3'h4; // status cmd + one read

  // ****************************************************
  // address layout and timing
  // ****************************************************
  localparam int         NSH_ADDR_BYTES = 5;
  localparam int         NSH_ADDR_USED  = 21;
  localparam int         NSH_TOP_BIT    = 20;
  localparam int         NSH_STROBE_NS  = 30;      // least strobe phase
  localparam int         NSH_CLK_MHZ    = 200;
  localparam int         NSH_PHASE_CYC  = (NSH_STROBE_NS * NSH_CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    NSH_IDLE  = 4'b0000,
    NSH_CMD   = 4'b0001,
    NSH_ADDRS = 4'b0010,
    NSH_CONF  = 4'b0011,
    NSH_WAIT  = 4'b0100,
    NSH_RDAT  = 4'b0101,
    NSH_WDAT  = 4'b0110,
    NSH_CLOSE = 4'b0111,
    NSH_DONE  = 4'b1000
  } nsh_state_type;

endpackage

// ==== rtl/nsh_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-low reset, clock enable
`timescale 1ns/1ps
module nsh_fifo
  import nsh_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  // ****************************************************
  // storage
  // ****************************************************
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end

  // honest flags straight from the count
  assign in_ready_o  = (count_r < (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = ce_i && in_valid_i && in_ready_o;
  assign pop         = ce_i && out_valid_o && out_ready_i;

  // data array, no reset needed
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop)  rd_ptr_r <= rd_ptr_r + AW'(1);
      if (push && !pop) count_r <= count_r + (AW+1)'(1);
      else if (pop && !push) count_r <= count_r - (AW+1)'(1);
    end
  end

endmodule

// ==== rtl/nsh_host.sv ====
// host controller driving a nand-style nvsram port
// assumes 200 MHz sys_clk_i; ready/busy pin arrives asynchronously
// Function
// - data words are launched so the write strobe rises with the other controls stable.
// - read strobe falls with latches low and write strobe high to fetch a word.
// - commands and address bytes travel on the low eight bus lines only.
// - address cycle pulses write strobe with address latch high, command latch low.
// - command cycle pulses write strobe with command latch high, address latch low.
// - in 16-bit mode the top address bit is forced to zero.
// - unused address bits and the fourth and fifth bytes are sent as zero.
// - array read sends 00h, five address bytes, 30h, then reads data.
// - array write sends 80h, five address bytes, data, then optional 10h.
// - five address bytes are sent least significant first.
`timescale 1ns/1ps
module nsh_host
  import nsh_pkg::*;
#(
  parameter int  DW        = 16,  // 8 or 16
  parameter int  FIFO_DEPTH = 8,
  parameter int  LEN_W     = 12
) (
  // clock, reset, enable
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  // operation request
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic [2:0]        req_op_i,
  input  wire logic [7:0]        req_cmd_i,
  input  wire logic [NSH_ADDR_USED-1:0] req_addr_i,
  input  wire logic [LEN_W-1:0]  req_len_i,
  input  wire logic              req_close_i,
  output logic                   busy_o,
  // write data in
  input  wire logic              wdat_valid_i,
  output logic                   wdat_ready_o,
  input  wire logic [DW-1:0]     wdat_i,
  // read data out
  output logic                   rdat_valid_o,
  input  wire logic              rdat_ready_i,
  output logic      [DW-1:0]     rdat_o,
  // device pins
  output logic                   chip_sel_n_o,
  output logic                   cmd_latch_o,
  output logic                   addr_latch_o,
  output logic                   write_strobe_n_o,
  output logic                   output_strobe_n_o,
  output logic      [DW-1:0]     dq_o,
  output logic                   dq_oe_o,
  input  wire logic [DW-1:0]     dq_i,
  input  wire logic              ready_busy_i
);

  initial begin
    if (DW != 8 && DW != 16) $error("bus width must be 8 or 16");
    if (NSH_PHASE_CYC < 1) $error("strobe phase too short");
  end

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic          rb_s1_r;
  logic          rb_s2_r;
  logic [DW-1:0] dq_s1_r;
  logic [DW-1:0] dq_s2_r;

  // two flops before any logic reads the pins
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else if (ce_i) begin
      rb_s1_r <= ready_busy_i;
      rb_s2_r <= rb_s1_r;
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ****************************************************
  // operation state
  // ****************************************************
  nsh_state_type      state_r;
  logic [2:0]         op_r;
  logic [7:0]         cmd_r;
  logic [39:0]        addr_r;
  logic [LEN_W-1:0]   left_r;
  logic               close_r;
  logic [2:0]         abyte_r;
  logic [7:0]         phase_r;
  logic               lowhalf_r;  // strobe low half of a bus cycle
  logic               fifo_valid;
  logic               fifo_ready;
  logic [DW-1:0]      fifo_data;
  logic               cap_r;

  // low byte on the bus, upper lines zero
  function automatic logic [DW-1:0] low_byte(input logic [7:0] b);
    return {{(DW-8){1'b0}}, b};
  endfunction

  // one bus cycle spends a phase low and a phase high
  logic phase_end;
  assign phase_end = (phase_r == 8'(NSH_PHASE_CYC - 1));
  logic cyc_end;
  assign cyc_end = phase_end && !lowhalf_r;

  assign req_ready_o  = (state_r == NSH_IDLE) && rb_s2_r;
  assign busy_o       = (state_r != NSH_IDLE);
  assign wdat_ready_o = (state_r == NSH_WDAT) && cyc_end && rb_s2_r;

  // phase counter paces every strobe
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      phase_r   <= '0;
      lowhalf_r <= 1'b1;
    end else if (ce_i) begin
      // a write beat only starts once its word is offered, so no strobe is cut short
      if (state_r == NSH_IDLE || state_r == NSH_WAIT || state_r == NSH_DONE ||
          (state_r == NSH_WDAT && !wdat_valid_i && lowhalf_r && phase_r == '0)) begin
        phase_r   <= '0;
        lowhalf_r <= 1'b1;
      end else if (phase_end) begin
        phase_r   <= '0;
        lowhalf_r <= !lowhalf_r;
      end else begin
        phase_r <= phase_r + 8'(1);
      end
    end
  end

  // sequencing of command, address, data cycles
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_r <= NSH_IDLE;
      op_r    <= NSH_OP_COMMAND;
      cmd_r   <= '0;
      addr_r  <= '0;
      left_r  <= '0;
      close_r <= 1'b0;
      abyte_r <= '0;
    end else if (ce_i) begin
      case (state_r)
        NSH_IDLE: begin
          if (req_valid_i && rb_s2_r) begin
            op_r    <= req_op_i;
            cmd_r   <= (req_op_i == NSH_OP_READ)   ? NSH_CMD_READ :
                       (req_op_i == NSH_OP_WRITE)  ? NSH_CMD_WRITE :
                       (req_op_i == NSH_OP_STATUS) ? NSH_CMD_STATUS : req_cmd_i;
            // zero the unused bits and the top bit in 16-bit mode
            addr_r  <= {19'h0_0000, (DW == 16) ? 1'b0 : req_addr_i[NSH_TOP_BIT],
                        req_addr_i[NSH_TOP_BIT-1:0]};
            left_r  <= req_len_i;
            close_r <= req_close_i;
            abyte_r <= '0;
            state_r <= NSH_CMD;
          end
        end
        NSH_CMD: begin
          if (cyc_end) begin
            if (op_r == NSH_OP_READ || op_r == NSH_OP_WRITE || op_r == NSH_OP_ADDR) state_r <= NSH_ADDRS;
            else if (op_r == NSH_OP_STATUS) state_r <= NSH_RDAT;
            else state_r <= NSH_WAIT;
          end
        end
        NSH_ADDRS: begin
          if (cyc_end) begin
            addr_r  <= {8'h00, addr_r[39:8]};
            abyte_r <= abyte_r + 3'(1);
            if (op_r == NSH_OP_ADDR || abyte_r == 3'(NSH_ADDR_BYTES - 1)) begin
              if (op_r == NSH_OP_READ) state_r <= NSH_CONF;
              else if (op_r == NSH_OP_WRITE) state_r <= (left_r == '0) ? NSH_CLOSE : NSH_WDAT;
              else state_r <= NSH_WAIT;
            end
          end
        end
        NSH_CONF: begin
          if (cyc_end) state_r <= NSH_WAIT;
        end
        NSH_WAIT: begin
          // device may drop ready; wait until it is released
          if (rb_s2_r) begin
            if ((op_r == NSH_OP_READ || op_r == NSH_OP_ADDR) && left_r != '0) state_r <= fifo_ready ? NSH_RDAT : NSH_WAIT;
            else state_r <= NSH_DONE;
          end
        end
        NSH_RDAT: begin
          if (cyc_end) begin
            left_r <= left_r - LEN_W'(1);
            if (op_r == NSH_OP_STATUS || left_r <= LEN_W'(1)) state_r <= NSH_DONE;
            else if (!fifo_ready) state_r <= NSH_WAIT; // full fifo: park until drained
          end
        end
        NSH_WDAT: begin
          if (cyc_end && wdat_valid_i && rb_s2_r) begin
            left_r <= left_r - LEN_W'(1);
            if (left_r == LEN_W'(1)) state_r <= close_r ? NSH_CLOSE : NSH_DONE;
          end
        end
        NSH_CLOSE: begin
          if (cyc_end) state_r <= NSH_DONE;
        end
        default: begin
          state_r <= NSH_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // pin drive
  // ****************************************************
  logic strobe_cyc;
  assign strobe_cyc = (state_r == NSH_CMD) || (state_r == NSH_ADDRS) || (state_r == NSH_CONF) ||
                      (state_r == NSH_CLOSE) || (state_r == NSH_WDAT && wdat_valid_i);

  // registered pin levels; controls settle a phase before the strobe rises
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      chip_sel_n_o      <= 1'b1;
      cmd_latch_o       <= 1'b0;
      addr_latch_o      <= 1'b0;
      write_strobe_n_o  <= 1'b1;
      output_strobe_n_o <= 1'b1;
      dq_o              <= '0;
      dq_oe_o           <= 1'b0;
    end else if (ce_i) begin
      chip_sel_n_o      <= (state_r == NSH_IDLE) || (state_r == NSH_DONE);
      cmd_latch_o       <= (state_r == NSH_CMD) || (state_r == NSH_CONF) || (state_r == NSH_CLOSE);
      addr_latch_o      <= (state_r == NSH_ADDRS);
      write_strobe_n_o  <= !(strobe_cyc && lowhalf_r);
      output_strobe_n_o <= !(state_r == NSH_RDAT && lowhalf_r);
      dq_oe_o           <= strobe_cyc;
      case (state_r)
        NSH_CMD:   dq_o <= low_byte(cmd_r);
        NSH_ADDRS: dq_o <= low_byte(addr_r[7:0]);
        NSH_CONF:  dq_o <= low_byte(NSH_CMD_READ_CONF);
        NSH_CLOSE: dq_o <= low_byte(NSH_CMD_WRITE_CONF);
        NSH_WDAT:  dq_o <= wdat_i;
        default:   dq_o <= dq_o;
      endcase
    end
  end

  // sample read data at the end of the strobe low phase (after pin sync lag)
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cap_r <= 1'b0;
    end else if (ce_i) begin
      cap_r <= (state_r == NSH_RDAT) && lowhalf_r && phase_end;
    end
  end

  // read fifo; a full fifo would drop a word so all but the status read stall via its ready
  nsh_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_rfifo (
    .sys_clk_i   (sys_clk_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .in_valid_i  (cap_r),
    .in_ready_o  (fifo_ready),
    .in_data_i   (dq_s2_r),
    .out_valid_o (fifo_valid),
    .out_ready_i (rdat_ready_i),
    .out_data_o  (fifo_data)
  );

  assign rdat_valid_o = fifo_valid;
  assign rdat_o       = fifo_data;

endmodule

// ==== verification/nsh_host_properties.sv ====
// checker for the nand-style host port pins
// assumes it is bound onto nsh_host with ce_i held high
`timescale 1ns/1ps
module nsh_host_chk
  import nsh_pkg::*;
#(
  parameter int DW = 16
) (
  // clock, reset, request side
  input wire logic          sys_clk_i,
  input wire logic          nrst_i,
  input wire logic          req_valid_i,
  input wire logic          req_ready_o,
  input wire logic          busy_o,
  input wire logic          ready_busy_i,
  // device pins
  input wire logic          chip_sel_n_o,
  input wire logic          cmd_latch_o,
  input wire logic          addr_latch_o,
  input wire logic          write_strobe_n_o,
  input wire logic          output_strobe_n_o,
  input wire logic          dq_oe_o,
  input wire logic [DW-1:0] dq_o
);
  // ****************************************
  // pin protocol
  // ****************************************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_rst_idle;
    $rose(nrst_i) |-> chip_sel_n_o && write_strobe_n_o && output_strobe_n_o && !dq_oe_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");

  property p_latch_excl;
    cmd_latch_o |-> !addr_latch_o;
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");

  property p_wr_cycle;
    !write_strobe_n_o |-> !chip_sel_n_o && output_strobe_n_o;
  endproperty
  a_wr_cycle: assert property (p_wr_cycle) else $error("write strobe low out of cycle");

  // controls must not move at the edge the device latches on
  property p_rise_hold;
    $rose(write_strobe_n_o) |-> $stable(cmd_latch_o) && $stable(addr_latch_o) && $stable(chip_sel_n_o) && $stable(dq_o);
  endproperty
  a_rise_hold: assert property (p_rise_hold) else $error("controls moved at strobe rise");

  property p_wr_phase;
    $fell(write_strobe_n_o) |-> !write_strobe_n_o [*6] ##1 write_strobe_n_o;
  endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("write strobe low phase wrong");

  property p_rd_phase;
    $fell(output_strobe_n_o) |->
      (!output_strobe_n_o && !cmd_latch_o && !addr_latch_o && write_strobe_n_o && !dq_oe_o) [*6]
      ##1 output_strobe_n_o;
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read strobe cycle wrong");

  // ready pin needs two flops before the host can see it
  property p_busy_hold;
    !ready_busy_i [*3] |-> !req_ready_o && !$fell(output_strobe_n_o);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("activity while device busy");

  property p_take_cmd;
    req_valid_i && req_ready_o |=> busy_o ##[0:2] (!chip_sel_n_o && cmd_latch_o);
  endproperty
  a_take_cmd: assert property (p_take_cmd) else $error("no command cycle after request");

  property p_idle_desel;
    !busy_o |-> chip_sel_n_o;
  endproperty
  a_idle_desel: assert property (p_idle_desel) else $error("selected while idle");
endmodule

bind nsh_host nsh_host_chk #(.DW(DW)) nsh_host_chk_inst (.sys_clk_i, .nrst_i, .req_valid_i, .req_ready_o,
  .busy_o, .ready_busy_i, .chip_sel_n_o, .cmd_latch_o, .addr_latch_o, .write_strobe_n_o,
  .output_strobe_n_o, .dq_oe_o, .dq_o);

// ==== verification/nsh_dev_model.sv ====
// behavioural model of the memory device behind the host port
// assumes pins straight from the host, dq resolved by the bench
`timescale 1ns/1ps
module nsh_dev_model (
  // control pins
  input  wire logic        ce_n_i,
  input  wire logic        cle_i,
  input  wire logic        ale_i,
  input  wire logic        we_n_i,
  input  wire logic        re_n_i,
  // bus and bench knobs
  input  wire logic [15:0] dq_i,
  input  wire logic        busy_i,
  input  wire logic        slow_i,
  output logic      [15:0] dq_o,
  output logic             rb_o,
  output logic      [7:0]  last_cmd_o
);
  // ****************************************
  // array, address and mode
  // ****************************************
  logic [15:0] mem [int];
  logic [39:0] adr = '0;
  logic [7:0]  mode = 8'hFF;
  logic [15:0] v;
  int          ptr = 0;
  assign rb_o = !busy_i;
  initial dq_o = 16'h0000;
  initial last_cmd_o = 8'h00;

  // all pins latched at the strobe rise; busy drops all but 70h and ffh
  always @(posedge we_n_i) begin
    if (!ce_n_i && re_n_i) begin
      if (cle_i && !ale_i && (!busy_i || dq_i[7:0] == 8'h70 || dq_i[7:0] == 8'hFF)) begin
        last_cmd_o = dq_i[7:0];
        if (dq_i[7:0] != 8'h30 && dq_i[7:0] != 8'h10) begin
          mode = dq_i[7:0];
          adr = '0;
        end
      end else if (ale_i && !cle_i && !busy_i) begin
        adr = {dq_i[7:0], adr[39:8]};
        ptr = int'(adr[20:0]);
      end else if (!ale_i && !cle_i && !busy_i && mode == 8'h80) begin
        mem[ptr] = dq_i;
        ptr++;
      end
    end
  end

  // one word per read strobe fall; slow mode answers late in the phase
  always @(negedge re_n_i) begin
    if (!ce_n_i && !cle_i && !ale_i && we_n_i && !busy_i) begin
      if (mode == 8'h70) v = 16'h0040;
      else if (mode == 8'h90 || mode == 8'hEC) v = {8'h00, mode ^ adr[39:32]};
      else begin
        v = mem[ptr];
        ptr++;
      end
      #(slow_i ? 12 : 2) dq_o = v;
    end
  end
  // released bus shows the inverse so stale data never passes
  always @(posedge re_n_i) dq_o = ~dq_o;
endmodule

// ==== verification/nsh_host_tb_top.sv ====
// self-checking bench: nsh_host against a behavioural device
// assumes the checker binds itself; one 200 MHz clock
`timescale 1ns/1ps
module nsh_host_tb_top
  import nsh_pkg::*;
;
  // ****************************************
  // signals, instances
  // ****************************************
  logic        sys_clk_i, nrst_i, req_valid_i, req_close_i, wdat_valid_i, rdat_ready_i;
  logic        req_ready_o, busy_o, wdat_ready_o, rdat_valid_o, cs_n, cle, ale, we_n, re_n, oe, rb;
  logic        busy_dev, slow, drain;
  logic [2:0]  req_op_i;
  logic [7:0]  req_cmd_i, last_cmd;
  logic [20:0] req_addr_i, a;
  logic [11:0] req_len_i;
  logic [15:0] wdat_i, rdat_o, host_dq, dev_dq, dq_bus, w;
  logic [15:0] wq[$], rq[$], ref_mem[int];
  logic [7:0]  cmds[8] = '{8'hFC, 8'h84, 8'hA5, 8'hA3, 8'hAC, 8'hEE, 8'hEF, 8'hFF};
  logic [7:0]  idc[2] = '{8'h90, 8'hEC};
  int          fails = 0, checks = 0, n;
  int unsigned seed = 71775;
  assign dq_bus = oe ? host_dq : dev_dq;

  nsh_host nsh_host_inst (.sys_clk_i, .nrst_i, .ce_i(1'b1), .req_valid_i, .req_ready_o, .req_op_i, .req_cmd_i,
    .req_addr_i, .req_len_i, .req_close_i, .busy_o, .wdat_valid_i, .wdat_ready_o, .wdat_i, .rdat_valid_o,
    .rdat_ready_i, .rdat_o, .chip_sel_n_o(cs_n), .cmd_latch_o(cle), .addr_latch_o(ale), .write_strobe_n_o(we_n),
    .output_strobe_n_o(re_n), .dq_o(host_dq), .dq_oe_o(oe), .dq_i(dq_bus), .ready_busy_i(rb));
  nsh_dev_model nsh_dev_model_inst (.ce_n_i(cs_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .re_n_i(re_n),
    .dq_i(dq_bus), .busy_i(busy_dev), .slow_i(slow), .dq_o(dev_dq), .rb_o(rb), .last_cmd_o(last_cmd));

  initial begin
    sys_clk_i = 0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk_i);
    #1 nrst_i = 0;
    repeat (5) @(posedge sys_clk_i);
    #1 nrst_i = 1;
  endtask
  // request held until taken, then wait for idle
  task automatic op(input logic [2:0] o, input logic [7:0] c, input logic [20:0] ad, input int len, input logic cl);
    int i;
    @(posedge sys_clk_i);
    #1 {req_op_i, req_cmd_i, req_addr_i, req_len_i, req_close_i} = {o, c, ad, 12'(len), cl};
    req_valid_i = 1;
    i = 0;
    do begin
      @(posedge sys_clk_i);
      i++;
    end while (req_ready_o !== 1'b1 && i < 400);
    if (req_ready_o !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    #1 req_valid_i = 0;
    for (i = 0; busy_o !== 1'b0 && i < 4000; i++) @(posedge sys_clk_i);
    if (busy_o !== 1'b0) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic wait_rq(input int len);
    for (int i = 0; rq.size() < len && i < 400; i++) @(posedge sys_clk_i);
    if (rq.size() < len) begin
      fails++;
      tally_and_finish();
    end
  endtask
  // stream driver: words taken at the edge, inputs changed just after
  always @(posedge sys_clk_i) begin
    if (wdat_valid_i && wdat_ready_o) void'(wq.pop_front());
    if (rdat_valid_o && rdat_ready_i) rq.push_back(rdat_o);
    #1 wdat_valid_i = (wq.size() > 0);
    wdat_i = (wq.size() > 0) ? wq[0] : 16'(rnd());
    rdat_ready_i = drain && (rnd() % 4 != 0);
  end
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    fails++;
    tally_and_finish();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {nrst_i, req_valid_i, req_close_i, busy_dev, slow, drain, wdat_valid_i, rdat_ready_i} = '0;
    {req_op_i, req_cmd_i, req_addr_i, req_len_i, wdat_i} = '0;
    do_reset();
    // writes with and without 10h, read back; first read fills the fifo
    for (int k = 0; k < 6; k++) begin
      a = 21'(rnd()) & 21'h0f_ffff;
      n = (k == 0) ? 8 : 1 + rnd() % 8;
      slow = k[1];
      for (int i = 0; i < n; i++) begin
        w = 16'(rnd());
        wq.push_back(w);
        ref_mem[a + i] = w;
      end
      op(NSH_OP_WRITE, 8'h00, a, n, k[0]);
      rq = {};
      drain = (k != 0);
      op(NSH_OP_READ, 8'h00, a, n, 1'b0);
      if (k == 0) begin
        repeat (20) @(posedge sys_clk_i);
        chk("fifo_held", rdat_valid_o, 1);
        drain = 1;
      end
      wait_rq(n);
      for (int i = 0; i < n; i++) chk("read_word", rq[i], ref_mem[a + i]);
    end
    foreach (cmds[i]) begin
      op(NSH_OP_COMMAND, cmds[i], '0, 0, 1'b0);
      chk("command_byte", last_cmd, cmds[i]);
    end
    rq = {};
    op(NSH_OP_STATUS, 8'h70, '0, 1, 1'b0);
    wait_rq(1);
    chk("status_word", rq[0], 16'h0040);
    foreach (idc[i]) begin
      rq = {};
      op(NSH_OP_ADDR, idc[i], 21'h00_0020, 2, 1'b0);
      wait_rq(2);
      chk("id_first", rq[0], {8'h00, idc[i] ^ 8'h20});
      chk("id_word", rq[1], {8'h00, idc[i] ^ 8'h20});
    end
    // device busy: host holds off, write lands after release
    busy_dev = 1;
    repeat (6) @(posedge sys_clk_i);
    chk("ready_while_busy", req_ready_o, 0);
    fork
      begin
        repeat (40) @(posedge sys_clk_i);
        #1 busy_dev = 0;
      end
    join_none
    a = 21'h00_1234;
    wq.push_back(16'hbeef);
    op(NSH_OP_WRITE, 8'h00, a, 1, 1'b1);
    // second reset mid-run, then the word must still read back
    do_reset();
    rq = {};
    op(NSH_OP_READ, 8'h00, a, 1, 1'b0);
    wait_rq(1);
    chk("after_busy_word", rq[0], 16'hbeef);
    tally_and_finish();
  end
endmodule
